//--- write_flush_buffer_path.sv
// Contract
// - Four pending 64-bit doubleword entries buffered
// - Loaded by uncached stores or dirty evictions
// - Stall pipeline on write while buffer full
// - Eight-word blocks sent as one transaction
// - 32-bit bus, no parity anywhere
// - Fast pattern one word per cycle, configurable
// - Cached stores update cache, written back later
// - Pattern field defaults only on power-on reset
module write_flush_buffer_path
  import flush_buffer_pkg::*;
#(
  parameter int ENTRIES = ENTRY_DEPTH,
  parameter int FDEPTH  = FIFO_DEPTH
) (
  input  wire logic              clock_i,
  input  wire logic              rst_i,
  input  wire logic              power_on_reset_input_i,
  input  wire logic              pattern_wr_i,
  input  wire logic              pattern_wdata_i,
  input  wire logic              uncached_store_i,
  input  wire logic              cached_store_i,
  input  wire logic [ADDR_W-1:0] store_addr_i,
  input  wire logic [ENTRY_W-1:0] store_data_i,
  input  wire logic              evict_valid_i,
  input  wire logic [ADDR_W-1:0] evict_addr_i,
  input  wire logic [ENTRY_W-1:0] evict_data_i,
  input  wire logic              evict_last_i,
  input  wire logic              bus_grant_i,
  output logic                   stall_o,
  output logic                   write_data_pattern_field_o,
  output logic                   bus_valid_o,
  output logic                   bus_addr_phase_o,
  output logic [BUS_W-1:0]       bus_ad_o,
  output logic                   bus_ad_oe_o,
  output logic                   bus_block_o,
  output logic                   bus_last_o,
  output logic [1:0]             pending_o
);

  // ----------------------------------------------------------------
  // Entry format: kind, address, doubleword, last flag
  // ----------------------------------------------------------------
  localparam int FW = 1 + ADDR_W + ENTRY_W + 1;
  localparam int CW = $clog2(ENTRIES + 1);

  logic           pattern_r;
  logic [CW-1:0]  entries_r;
  logic           stall_r;
  bus_state_t     state_r;
  bus_state_t     state_nxt;
  logic           half_r;
  logic [1:0]     pending_r;
  logic           valid_r;
  logic           addr_ph_r;
  logic [BUS_W-1:0] ad_r;
  logic           oe_r;
  logic           block_r;
  logic           last_r;

  logic           in_valid;
  logic           in_ready;
  logic [FW-1:0]  in_data;
  logic           out_valid;
  logic           out_ready;
  logic [FW-1:0]  out_data;
  logic           room;
  logic           write_req;
  logic           push;
  logic           pop;
  logic           head_kind;
  logic [ADDR_W-1:0] head_addr;
  logic [ENTRY_W-1:0] head_data;
  logic           head_last;
  logic [BUS_W-1:0] head_word;
  logic           entry_done;

  // ----------------------------------------------------------------
  // Configuration field
  // ----------------------------------------------------------------
  // Cold default only
  // Warm reset leaves the field as software set it.
  always_ff @(posedge clock_i) begin
    if (power_on_reset_input_i) begin
      pattern_r <= PATTERN_RESET;
    end else if (pattern_wr_i) begin
      pattern_r <= pattern_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Filling side
  // ----------------------------------------------------------------
  // Two load sources
  // Cached stores bypass
  // Cached stores only touch the cache; they never enter here.
  assign write_req = uncached_store_i || evict_valid_i;
  assign in_valid  = write_req && room;
  assign in_data   = evict_valid_i ? {KIND_BLOCK, evict_addr_i, evict_data_i, evict_last_i}
                                   : {KIND_SINGLE, store_addr_i, store_data_i, 1'b1};
  assign room      = (entries_r != CW'(ENTRIES)) && in_ready && !stall_r;
  assign push      = in_valid;
  assign pop       = out_valid && out_ready;

  assign {head_kind, head_addr, head_data, head_last} = out_data;
  assign head_word  = half_r ? head_data[ENTRY_W-1:BUS_W] : head_data[BUS_W-1:0];
  assign entry_done = (state_r == ST_DATA) && half_r && bus_grant_i;
  assign out_ready  = entry_done;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      entries_r <= '0;
    end else begin
      entries_r <= entries_r + CW'(push) - CW'(pop);
    end
  end

  // Interlock until empty
  // Holding until fully empty is coarse but keeps stores ordered simply.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stall_r <= 1'b0;
    end else if (stall_r) begin
      stall_r <= (entries_r != '0) || out_valid;
    end else begin
      stall_r <= write_req && !room;
    end
  end

  word_fifo #(
    .WIDTH (FW),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (in_valid),
    .in_ready_o  (in_ready),
    .in_data_i   (in_data),
    .out_valid_o (out_valid),
    .out_ready_i (out_ready),
    .out_data_o  (out_data)
  );

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (out_valid && bus_grant_i) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (bus_grant_i) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (entry_done) begin
          if (head_kind == KIND_BLOCK && !head_last) begin
            state_nxt = ST_DATA;
          end else begin
            state_nxt = ST_IDLE;
          end
        end else if (bus_grant_i && pattern_r == PATTERN_GAPPED) begin
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        state_nxt = ST_DATA;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      half_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_ADDR) begin
        half_r <= 1'b0;
      end else if (state_r == ST_DATA && bus_grant_i) begin
        half_r <= !half_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Plain 32-bit, no parity
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      valid_r   <= 1'b0;
      addr_ph_r <= 1'b0;
      ad_r      <= '0;
      oe_r      <= 1'b0;
      block_r   <= 1'b0;
      last_r    <= 1'b0;
      pending_r <= 2'h0;
    end else begin
      pending_r <= {stall_r, out_valid};
      valid_r   <= (state_r == ST_ADDR || state_r == ST_DATA) && bus_grant_i;
      addr_ph_r <= (state_r == ST_ADDR) && bus_grant_i;
      ad_r      <= (state_r == ST_ADDR) ? head_addr : head_word;
      oe_r      <= state_r != ST_IDLE;
      block_r   <= head_kind;
      last_r    <= entry_done && head_last;
    end
  end

  assign stall_o                    = stall_r;
  assign write_data_pattern_field_o = pattern_r;
  assign bus_valid_o                = valid_r;
  assign bus_addr_phase_o           = addr_ph_r;
  assign bus_ad_o                   = ad_r;
  assign bus_ad_oe_o                = oe_r;
  assign bus_block_o                = block_r;
  assign bus_last_o                 = last_r;
  assign pending_o                  = pending_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_limit;
    @(posedge clock_i) disable iff (rst_i) entries_r <= CW'(ENTRIES);
  endproperty
  a_limit : assert property (p_limit) else $error("more than four entries");

  property p_stall_full;
    @(posedge clock_i) disable iff (rst_i)
      (write_req && entries_r == CW'(ENTRIES) && !stall_r) |=> stall_r;
  endproperty
  a_stall_full : assert property (p_stall_full) else $error("no stall on full");

  property p_no_push_stalled;
    @(posedge clock_i) disable iff (rst_i) stall_r |-> !push;
  endproperty
  a_no_push_stalled : assert property (p_no_push_stalled) else $error("push while stalled");

  property p_cached_ignored;
    @(posedge clock_i) disable iff (rst_i)
      (cached_store_i && !uncached_store_i && !evict_valid_i) |-> !push;
  endproperty
  a_cached_ignored : assert property (p_cached_ignored) else $error("cached store queued");

  sequence s_fast_beat;
    state_r == ST_DATA && bus_grant_i && !half_r && pattern_r == PATTERN_FAST;
  endsequence
  property p_fast;
    @(posedge clock_i) disable iff (rst_i) s_fast_beat |=> state_r == ST_DATA;
  endproperty
  a_fast : assert property (p_fast) else $error("fast pattern gapped");

  property p_gap;
    @(posedge clock_i) disable iff (rst_i)
      (state_r == ST_DATA && bus_grant_i && !half_r && pattern_r == PATTERN_GAPPED)
      |=> state_r == ST_GAP ##1 state_r == ST_DATA;
  endproperty
  a_gap : assert property (p_gap) else $error("gapped pattern wrong");

  property p_block_cont;
    @(posedge clock_i) disable iff (rst_i)
      (entry_done && head_kind == KIND_BLOCK && !head_last) |=> state_r == ST_DATA;
  endproperty
  a_block_cont : assert property (p_block_cont) else $error("block split");

  property p_cold;
    @(posedge clock_i) power_on_reset_input_i |=> pattern_r == PATTERN_RESET;
  endproperty
  a_cold : assert property (p_cold) else $error("pattern not defaulted");

  property p_order;
    @(posedge clock_i) disable iff (rst_i)
      pop |=> bus_valid_o && bus_ad_o == $past(head_data[ENTRY_W-1:BUS_W]);
  endproperty
  a_order : assert property (p_order) else $error("drain out of order");

endmodule : write_flush_buffer_path

//--- flush_buffer_pkg.sv
package flush_buffer_pkg;

  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int ENTRY_W       = 64;
  localparam int ADDR_W        = 32;
  localparam int BUS_W         = 32;
  localparam int ENTRY_DEPTH   = 4;
  localparam int FIFO_DEPTH    = 16;
  localparam int LINE_WORDS    = 8;
  localparam int BEAT_CNT_W    = 3;

  // ----------------------------------------------------------------
  // Write data pattern field
  // ----------------------------------------------------------------
  localparam logic PATTERN_FAST   = 1'b0;
  localparam logic PATTERN_GAPPED = 1'b1;
  localparam logic PATTERN_RESET  = PATTERN_FAST;

  // ----------------------------------------------------------------
  // Block kinds
  // ----------------------------------------------------------------
  localparam logic KIND_SINGLE = 1'b0;
  localparam logic KIND_BLOCK  = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_GAP
  } bus_state_t;

endpackage : flush_buffer_pkg

//--- word_fifo.sv
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wptr_r;
  logic [PW-1:0]    rptr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != (PW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == PW'(DEPTH - 1)) ? '0 : wptr_r + PW'(1);
      end
      if (pop) begin
        rptr_r <= (rptr_r == PW'(DEPTH - 1)) ? '0 : rptr_r + PW'(1);
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  property p_no_overflow;
    @(posedge clock_i) disable iff (rst_i) count_r <= (PW+1)'(DEPTH);
  endproperty
  a_no_overflow : assert property (p_no_overflow) else $error("fifo count above depth");

endmodule : word_fifo

//--- flush_agent_model.sv
module flush_agent_model
  import flush_buffer_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             hold_i,
  input  wire logic             slow_i,
  input  wire logic             bus_valid_i,
  input  wire logic             bus_addr_phase_i,
  input  wire logic [BUS_W-1:0] bus_ad_i,
  output logic                  bus_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic             tick_r;
  int               cyc_r;
  logic [BUS_W:0]   beats[$];
  int               when[$];
  // Slow mode grants every other cycle
  assign bus_grant_o = !hold_i && (!slow_i || tick_r);
  // plain 32-bit beats
  // No parity lane exists to check
  always @(posedge clock_i) begin
    if (rst_i) begin
      tick_r <= 1'b0;
      cyc_r  <= 0;
    end else begin
      tick_r <= ~tick_r;
      cyc_r  <= cyc_r + 1;
      if (bus_valid_i) begin
        beats.push_back({bus_addr_phase_i, bus_ad_i});
        when.push_back(cyc_r);
      end
    end
  end
endmodule : flush_agent_model

//--- test_write_flush_buffer_path.sv
module test_write_flush_buffer_path;
  import flush_buffer_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, a, b); end end
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_i, rst_i, por_i, pattern_wr_i, pattern_wdata_i, hold, slow;
  logic uncached_store_i, cached_store_i, evict_valid_i, evict_last_i;
  logic [31:0] store_addr_i, evict_addr_i, bus_ad_o;
  logic [63:0] store_data_i, evict_data_i;
  logic bus_grant_i, stall_o, field_o, bus_valid_o, bus_addr_phase_o;
  logic [1:0] pending_o;
  logic oe_o, block_o, last_o;
  int last_cnt, blk_cnt;
  logic [32:0] exp[$];
  int bad_count, cmp_count, n;
  typedef struct {logic uc; logic [31:0] a; logic [63:0] d; int nb;} row_t;
  row_t rows[3] = '{'{1'b1, 32'h0000_0100, 64'h0123_4567_89AB_CDEF, 3},
                    '{1'b0, 32'h0000_0200, 64'hFFFF_0000_FFFF_0000, 0},
                    '{1'b1, 32'hFFFF_FFF8, 64'h8000_0001_7FFF_FFFE, 3}};
  write_flush_buffer_path dut_u (.clock_i(clock_i), .rst_i(rst_i),
    .power_on_reset_input_i(por_i), .pattern_wr_i(pattern_wr_i),
    .pattern_wdata_i(pattern_wdata_i), .uncached_store_i(uncached_store_i),
    .cached_store_i(cached_store_i), .store_addr_i(store_addr_i), .store_data_i(store_data_i),
    .evict_valid_i(evict_valid_i), .evict_addr_i(evict_addr_i), .evict_data_i(evict_data_i),
    .evict_last_i(evict_last_i), .bus_grant_i(bus_grant_i), .stall_o(stall_o),
    .write_data_pattern_field_o(field_o), .bus_valid_o(bus_valid_o),
    .bus_addr_phase_o(bus_addr_phase_o), .bus_ad_o(bus_ad_o), .bus_ad_oe_o(oe_o),
    .bus_block_o(block_o), .bus_last_o(last_o), .pending_o(pending_o));
  always @(posedge clock_i) begin
    if (last_o === 1'b1) last_cnt++;
    if (bus_valid_o === 1'b1 && block_o === 1'b1) blk_cnt++;
  end
  flush_agent_model agent_u (.clock_i(clock_i), .rst_i(rst_i), .hold_i(hold), .slow_i(slow),
    .bus_valid_i(bus_valid_o), .bus_addr_phase_i(bus_addr_phase_o), .bus_ad_i(bus_ad_o),
    .bus_grant_o(bus_grant_i));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic push(input logic uc, input logic [31:0] a, input logic [63:0] d);
    @(posedge clock_i);
    uncached_store_i <= uc;
    cached_store_i   <= !uc;
    store_addr_i     <= a;
    store_data_i     <= d;
  endtask : push
  task automatic idle_in;
    @(posedge clock_i);
    {uncached_store_i, cached_store_i, evict_valid_i, evict_last_i, pattern_wr_i} <= 5'h00;
  endtask : idle_in
  // Tail beats can follow the last FIFO pop
  task automatic drain;
    for (n = 0; n < 400 && pending_o !== 2'b00; n++) @(posedge clock_i);
    repeat (14) @(posedge clock_i);
  endtask : drain
  task automatic add_entry(input logic [31:0] a, input logic [63:0] d, input logic hd);
    if (hd) exp.push_back({1'b1, a});
    exp.push_back({1'b0, d[31:0]});
    exp.push_back({1'b0, d[63:32]});
  endtask : add_entry
  task automatic cmp_beats;
    `CHK(agent_u.beats.size(), exp.size())
    foreach (exp[k]) if (k < agent_u.beats.size()) `CHK(agent_u.beats[k], exp[k])
    agent_u.beats.delete();
    agent_u.when.delete();
    exp.delete();
  endtask : cmp_beats
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #300us;
    bad_count++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_i, por_i} = 2'b11;
    {pattern_wr_i, pattern_wdata_i, hold, slow, evict_last_i} = 5'h00;
    {uncached_store_i, cached_store_i, evict_valid_i} = 3'h0;
    {store_addr_i, evict_addr_i, store_data_i, evict_data_i} = '0;
    repeat (6) @(posedge clock_i);
    {rst_i, por_i} <= 2'b00;
    @(posedge clock_i);
    #1 `CHK({oe_o, stall_o, bus_valid_o, pending_o}, 5'h00)
    `CHK(field_o, PATTERN_RESET)
    foreach (rows[i]) begin
      push(rows[i].uc, rows[i].a, rows[i].d);
      idle_in();
      drain();
      `CHK(agent_u.beats.size(), rows[i].nb)
      if (rows[i].nb != 0) `CHK(agent_u.when[2] - agent_u.when[1], 1)
      if (rows[i].uc) add_entry(rows[i].a, rows[i].d, 1'b1);
      cmp_beats();
    end
    `CHK(last_cnt, 2)
    $display("rows done");
    hold <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      push(1'b1, 32'h0000_1000 + 32'(i * 8), 64'hA5A5_0000_5A5A_0000 + 64'(i));
      if (i < 4) add_entry(32'h0000_1000 + 32'(i * 8), 64'hA5A5_0000_5A5A_0000 + 64'(i), 1'b1);
    end
    idle_in();
    repeat (2) @(posedge clock_i);
    #1 `CHK(stall_o, 1'b1)
    hold <= 1'b0;
    for (n = 0; n < 400 && stall_o !== 1'b0; n++) @(posedge clock_i);
    #1 `CHK(pending_o[0], 1'b0)
    drain();
    cmp_beats();
    `CHK(last_cnt, 6)
    $display("full buffer done");
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock_i);
      evict_valid_i <= 1'b1;
      evict_addr_i  <= 32'h0000_2000 + 32'(i * 8);
      evict_data_i  <= 64'h1111_0000_2222_0000 + 64'(i);
      evict_last_i  <= (i == 3);
      add_entry(32'h0000_2000, 64'h1111_0000_2222_0000 + 64'(i), i == 0);
    end
    idle_in();
    drain();
    slow <= 1'b0;
    cmp_beats();
    `CHK(last_cnt, 7)
    `CHK(blk_cnt, 9)
    $display("block done");
    @(posedge clock_i);
    pattern_wr_i    <= 1'b1;
    pattern_wdata_i <= PATTERN_GAPPED;
    idle_in();
    push(1'b1, 32'h0000_0300, 64'hDEAD_BEEF_CAFE_F00D);
    idle_in();
    drain();
    `CHK(field_o, PATTERN_GAPPED)
    `CHK(agent_u.when[2] - agent_u.when[1], 2)
    `CHK({oe_o, last_cnt}, {1'b0, 32'd8})
    add_entry(32'h0000_0300, 64'hDEAD_BEEF_CAFE_F00D, 1'b1);
    cmp_beats();
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1 `CHK(field_o, PATTERN_GAPPED)
    por_i <= 1'b1;
    @(posedge clock_i);
    por_i <= 1'b0;
    @(posedge clock_i);
    #1 `CHK(field_o, PATTERN_RESET)
    $display("pattern done");
    tally_and_finish();
  end
endmodule : test_write_flush_buffer_path
